// ### verilog/pie_enable_top.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

//Contract
// RULE1 - Bit 7 bank A gates parallel slave
// RULE2 - Bit 6 bank A gates converter
// RULE3 - Bit 5 bank A gates serial receive
// RULE4 - Bit 4 bank A gates serial transmit
// RULE5 - Bit 3 bank A gates sync serial
// RULE6 - Bit 2 bank A gates capcomp A
// RULE7 - Bit 1 bank A gates period match
// RULE8 - Bit 0 bank A gates timer A
// RULE9 - Bank B bits 7,5,4 read zero
// RULE10 - Bit 6 bank B gates comparator
// RULE11 - Bit 1 bank B gates timer C
// RULE12 - Bit 0 bank B gates capcomp B
// RULE13 - Bit 7 CAN bank gates invalid message
// RULE14 - Bit 6 CAN bank gates bus wake
// RULE15 - Bit 5 CAN bank gates bus error
// RULE16 - Bits 4..2 CAN gate transmit buffers 2..0
// RULE17 - Bits 1..0 CAN gate receive buffers 1..0
// RULE18 - Bank B bits 3,2 gate collision, low voltage
// RULE19 - Request needs flag and enable; flag kept
module pie_enable_top
    import pie_pkg::*;
(
    // APB clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral flags, first bank.
    input wire logic parallel_slave_flag,
    input wire logic converter_flag,
    input wire logic serial_rx_flag,
    input wire logic serial_tx_flag,
    input wire logic sync_serial_flag,
    input wire logic capcomp_a_flag,
    input wire logic period_timer_match_flag,
    input wire logic timer_a_overflow_flag,
    // Peripheral flags, second bank.
    input wire logic comparator_flag,
    input wire logic bus_collision_flag,
    input wire logic low_voltage_flag,
    input wire logic timer_c_overflow_flag,
    input wire logic capcomp_b_flag,
    // CAN controller flags.
    input wire logic invalid_msg_flag,
    input wire logic bus_wake_flag,
    input wire logic bus_error_flag,
    input wire logic tx_buffer2_flag,
    input wire logic tx_buffer1_flag,
    input wire logic tx_buffer0_flag,
    input wire logic rx_buffer1_flag,
    input wire logic rx_buffer0_flag,
    // Gated requests to the core interrupt logic.
    output logic parallel_slave_irq_req,
    output logic converter_irq_req,
    output logic serial_rx_irq_req,
    output logic serial_tx_irq_req,
    output logic sync_serial_irq_req,
    output logic capcomp_a_irq_req,
    output logic period_timer_match_irq_req,
    output logic timer_a_overflow_irq_req,
    output logic comparator_irq_req,
    output logic bus_collision_irq_req,
    output logic low_voltage_irq_req,
    output logic timer_c_overflow_irq_req,
    output logic capcomp_b_irq_req,
    output logic invalid_msg_irq_req,
    output logic bus_wake_irq_req,
    output logic bus_error_irq_req,
    output logic tx_buffer2_irq_req,
    output logic tx_buffer1_irq_req,
    output logic tx_buffer0_irq_req,
    output logic rx_buffer1_irq_req,
    output logic rx_buffer0_irq_req,
    // Summary interrupt.
    output logic irq
);

    logic [7:0] peripheral_irq_enable_a;
    logic [7:0] peripheral_irq_enable_b;
    logic [7:0] can_irq_enable;
    logic [23:0] irq_status;
    logic [23:0] irq_mask;
    logic [23:0] all_request;
    logic [23:0] all_rise;
    logic [23:0] next_irq_status;
    logic [23:0] status_clear;
    logic [31:0] next_prdata;
    logic addr_ok;
    logic wr_commit;
    logic rd_sample;
    pie_apb_state_t state;
    pie_apb_state_t next_state;

    pie_bank_if bank_a ();
    pie_bank_if bank_b ();
    pie_bank_if bank_can ();

    // Flags enter each bank at their documented bit position.
    always_comb begin
        bank_a.flag = 8'h00;
        bank_a.flag[PIE_BIT_PARALLEL_SLAVE] = parallel_slave_flag;
        bank_a.flag[PIE_BIT_CONVERTER] = converter_flag;
        bank_a.flag[PIE_BIT_SERIAL_RX] = serial_rx_flag;
        bank_a.flag[PIE_BIT_SERIAL_TX] = serial_tx_flag;
        bank_a.flag[PIE_BIT_SYNC_SERIAL] = sync_serial_flag;
        bank_a.flag[PIE_BIT_CAPCOMP_A] = capcomp_a_flag;
        bank_a.flag[PIE_BIT_PERIOD_MATCH] = period_timer_match_flag;
        bank_a.flag[PIE_BIT_TIMER_A] = timer_a_overflow_flag;
    end

    always_comb begin
        bank_b.flag = 8'h00;
        bank_b.flag[PIE_BIT_COMPARATOR] = comparator_flag;
        bank_b.flag[PIE_BIT_BUS_COLLISION] = bus_collision_flag;
        bank_b.flag[PIE_BIT_LOW_VOLTAGE] = low_voltage_flag;
        bank_b.flag[PIE_BIT_TIMER_C] = timer_c_overflow_flag;
        bank_b.flag[PIE_BIT_CAPCOMP_B] = capcomp_b_flag;
    end

    always_comb begin
        bank_can.flag = 8'h00;
        bank_can.flag[PIE_BIT_INVALID_MSG] = invalid_msg_flag;
        bank_can.flag[PIE_BIT_BUS_WAKE] = bus_wake_flag;
        bank_can.flag[PIE_BIT_BUS_ERROR] = bus_error_flag;
        bank_can.flag[PIE_BIT_TX_BUFFER2] = tx_buffer2_flag;
        bank_can.flag[PIE_BIT_TX_BUFFER1] = tx_buffer1_flag;
        bank_can.flag[PIE_BIT_TX_BUFFER0] = tx_buffer0_flag;
        bank_can.flag[PIE_BIT_RX_BUFFER1] = rx_buffer1_flag;
        bank_can.flag[PIE_BIT_RX_BUFFER0] = rx_buffer0_flag;
    end

    assign bank_a.enable = peripheral_irq_enable_a; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
    assign bank_b.enable = peripheral_irq_enable_b; // RULE10 RULE11 RULE12 RULE18
    assign bank_can.enable = can_irq_enable; // RULE13 RULE14 RULE15 RULE16 RULE17

    pie_bank_gate u_gate_a (
        .pclk(pclk),
        .presetn(presetn),
        .bank(bank_a.gate)
    );

    pie_bank_gate u_gate_b (
        .pclk(pclk),
        .presetn(presetn),
        .bank(bank_b.gate)
    );

    pie_bank_gate u_gate_can (
        .pclk(pclk),
        .presetn(presetn),
        .bank(bank_can.gate)
    );

    // Requests leave straight from the gate flip-flops.
    assign parallel_slave_irq_req = bank_a.request[PIE_BIT_PARALLEL_SLAVE]; // RULE1
    assign converter_irq_req = bank_a.request[PIE_BIT_CONVERTER]; // RULE2
    assign serial_rx_irq_req = bank_a.request[PIE_BIT_SERIAL_RX]; // RULE3
    assign serial_tx_irq_req = bank_a.request[PIE_BIT_SERIAL_TX]; // RULE4
    assign sync_serial_irq_req = bank_a.request[PIE_BIT_SYNC_SERIAL]; // RULE5
    assign capcomp_a_irq_req = bank_a.request[PIE_BIT_CAPCOMP_A]; // RULE6
    assign period_timer_match_irq_req = bank_a.request[PIE_BIT_PERIOD_MATCH]; // RULE7
    assign timer_a_overflow_irq_req = bank_a.request[PIE_BIT_TIMER_A]; // RULE8
    assign comparator_irq_req = bank_b.request[PIE_BIT_COMPARATOR]; // RULE10
    assign bus_collision_irq_req = bank_b.request[PIE_BIT_BUS_COLLISION]; // RULE18
    assign low_voltage_irq_req = bank_b.request[PIE_BIT_LOW_VOLTAGE]; // RULE18
    assign timer_c_overflow_irq_req = bank_b.request[PIE_BIT_TIMER_C]; // RULE11
    assign capcomp_b_irq_req = bank_b.request[PIE_BIT_CAPCOMP_B]; // RULE12
    assign invalid_msg_irq_req = bank_can.request[PIE_BIT_INVALID_MSG]; // RULE13
    assign bus_wake_irq_req = bank_can.request[PIE_BIT_BUS_WAKE]; // RULE14
    assign bus_error_irq_req = bank_can.request[PIE_BIT_BUS_ERROR]; // RULE15
    assign tx_buffer2_irq_req = bank_can.request[PIE_BIT_TX_BUFFER2]; // RULE16
    assign tx_buffer1_irq_req = bank_can.request[PIE_BIT_TX_BUFFER1]; // RULE16
    assign tx_buffer0_irq_req = bank_can.request[PIE_BIT_TX_BUFFER0]; // RULE16
    assign rx_buffer1_irq_req = bank_can.request[PIE_BIT_RX_BUFFER1]; // RULE17
    assign rx_buffer0_irq_req = bank_can.request[PIE_BIT_RX_BUFFER0]; // RULE17

    assign all_request = {bank_can.request, bank_b.request, bank_a.request};
    assign all_rise = {bank_can.rise, bank_b.rise, bank_a.rise};

    // APB handshake: one wait cycle so that pready and prdata come from flip-flops.
    always_comb begin
        case (state)
            PIE_ST_IDLE: begin
                next_state = (psel && !penable) ? PIE_ST_WAIT : PIE_ST_IDLE;
            end
            PIE_ST_WAIT: begin
                next_state = (psel && penable) ? PIE_ST_RESP : PIE_ST_WAIT;
            end
            PIE_ST_RESP: begin
                next_state = PIE_ST_IDLE;
            end
            default: begin
                next_state = PIE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PIE_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= (state == PIE_ST_WAIT) && psel && penable;
        end
    end

    always_comb begin
        case (paddr)
            PIE_OFF_ENABLE_A,
            PIE_OFF_ENABLE_B,
            PIE_OFF_CAN_ENABLE,
            PIE_OFF_IRQ_STATUS,
            PIE_OFF_IRQ_MASK,
            PIE_OFF_REQ_VIEW: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // Writes land on the edge where the master sees pready high.
    assign wr_commit = psel && penable && pready && pwrite && addr_ok;
    assign rd_sample = (state == PIE_ST_WAIT) && psel && penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= (state == PIE_ST_WAIT) && psel && penable && !addr_ok;
        end
    end

    always_comb begin
        next_prdata = 32'h00000000;
        case (paddr)
            PIE_OFF_ENABLE_A: begin
                next_prdata[7:0] = peripheral_irq_enable_a;
            end
            PIE_OFF_ENABLE_B: begin
                next_prdata[7:0] = peripheral_irq_enable_b & PIE_IMPL_ENABLE_B; // RULE9
            end
            PIE_OFF_CAN_ENABLE: begin
                next_prdata[7:0] = can_irq_enable;
            end
            PIE_OFF_IRQ_STATUS: begin
                next_prdata[23:0] = irq_status;
            end
            PIE_OFF_IRQ_MASK: begin
                next_prdata[23:0] = irq_mask;
            end
            PIE_OFF_REQ_VIEW: begin
                next_prdata[23:0] = all_request;
            end
            default: begin
                next_prdata = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_sample) begin
            prdata <= next_prdata;
        end else if (state == PIE_ST_RESP) begin
            prdata <= 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_enable_a <= PIE_RST_ENABLE_A;
        end else if (wr_commit && paddr == PIE_OFF_ENABLE_A) begin
            peripheral_irq_enable_a <= pwdata[7:0] & PIE_IMPL_ENABLE_A;
        end
    end

    // Unimplemented bits never store, so they cannot leak into the gate.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_enable_b <= PIE_RST_ENABLE_B;
        end else if (wr_commit && paddr == PIE_OFF_ENABLE_B) begin
            peripheral_irq_enable_b <= pwdata[7:0] & PIE_IMPL_ENABLE_B; // RULE9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_irq_enable <= PIE_RST_CAN_ENABLE;
        end else if (wr_commit && paddr == PIE_OFF_CAN_ENABLE) begin
            can_irq_enable <= pwdata[7:0] & PIE_IMPL_CAN_ENABLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= PIE_RST_IRQ_MASK;
        end else if (wr_commit && paddr == PIE_OFF_IRQ_MASK) begin
            irq_mask <= pwdata[23:0];
        end
    end

    // A request that rises in the cycle of a clearing write still sets its bit.
    always_comb begin
        status_clear = 24'h000000;
        if (wr_commit && paddr == PIE_OFF_IRQ_STATUS) begin
            status_clear = pwdata[23:0];
        end
        next_irq_status = (irq_status & ~status_clear) | all_rise;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= PIE_RST_IRQ_STATUS;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status & irq_mask);
        end
    end

endmodule

`default_nettype wire

// ### verilog/pie_pkg.sv
package pie_pkg;

    localparam int PIE_BANK_W = 8;
    localparam int PIE_ADDR_W = 8;
    localparam int PIE_IRQ_W = 3 * PIE_BANK_W;

    // Register byte offsets on the APB side.
    localparam logic [7:0] PIE_OFF_ENABLE_A = 8'h00;
    localparam logic [7:0] PIE_OFF_ENABLE_B = 8'h04;
    localparam logic [7:0] PIE_OFF_CAN_ENABLE = 8'h08;
    localparam logic [7:0] PIE_OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] PIE_OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] PIE_OFF_REQ_VIEW = 8'h14;

    // Values after reset.
    localparam logic [7:0] PIE_RST_ENABLE_A = 8'h00;
    localparam logic [7:0] PIE_RST_ENABLE_B = 8'h00;
    localparam logic [7:0] PIE_RST_CAN_ENABLE = 8'hff;
    localparam logic [23:0] PIE_RST_IRQ_STATUS = 24'h000000;
    localparam logic [23:0] PIE_RST_IRQ_MASK = 24'h000000;

    // Implemented bits of each enable bank.
    localparam logic [7:0] PIE_IMPL_ENABLE_A = 8'hff;
    localparam logic [7:0] PIE_IMPL_ENABLE_B = 8'h4f;
    localparam logic [7:0] PIE_IMPL_CAN_ENABLE = 8'hff;

    // First enable bank.
    localparam int PIE_BIT_PARALLEL_SLAVE = 7;
    localparam int PIE_BIT_CONVERTER = 6;
    localparam int PIE_BIT_SERIAL_RX = 5;
    localparam int PIE_BIT_SERIAL_TX = 4;
    localparam int PIE_BIT_SYNC_SERIAL = 3;
    localparam int PIE_BIT_CAPCOMP_A = 2;
    localparam int PIE_BIT_PERIOD_MATCH = 1;
    localparam int PIE_BIT_TIMER_A = 0;

    // Second enable bank.
    localparam int PIE_BIT_COMPARATOR = 6;
    localparam int PIE_BIT_BUS_COLLISION = 3;
    localparam int PIE_BIT_LOW_VOLTAGE = 2;
    localparam int PIE_BIT_TIMER_C = 1;
    localparam int PIE_BIT_CAPCOMP_B = 0;

    // CAN enable bank.
    localparam int PIE_BIT_INVALID_MSG = 7;
    localparam int PIE_BIT_BUS_WAKE = 6;
    localparam int PIE_BIT_BUS_ERROR = 5;
    localparam int PIE_BIT_TX_BUFFER2 = 4;
    localparam int PIE_BIT_TX_BUFFER1 = 3;
    localparam int PIE_BIT_TX_BUFFER0 = 2;
    localparam int PIE_BIT_RX_BUFFER1 = 1;
    localparam int PIE_BIT_RX_BUFFER0 = 0;

    // Field positions of the three banks inside the status and mask words.
    localparam int PIE_LSB_A = 0;
    localparam int PIE_LSB_B = 8;
    localparam int PIE_LSB_CAN = 16;

    typedef enum logic [2:0] {
        PIE_ST_IDLE = 3'b001,
        PIE_ST_WAIT = 3'b010,
        PIE_ST_RESP = 3'b100
    } pie_apb_state_t;

endpackage

// ### verilog/pie_bank_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pie_bank_if;
    logic [7:0] flag;
    logic [7:0] enable;
    logic [7:0] request;
    logic [7:0] rise;

    modport gate (
        input flag,
        input enable,
        output request,
        output rise
    );

    modport ctrl (
        output flag,
        output enable,
        input request,
        input rise
    );
endinterface

`default_nettype wire

// ### verilog/pie_bank_gate.sv
`timescale 1ns/1ps
`default_nettype none

module pie_bank_gate
    import pie_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bank signals.
    pie_bank_if.gate bank
);

    logic [7:0] next_request;

    // A cleared enable only hides the request; the flag itself is never touched.
    assign next_request = bank.flag & bank.enable; // RULE19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank.request <= 8'h00;
        end else begin
            bank.request <= next_request;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank.rise <= 8'h00;
        end else begin
            bank.rise <= next_request & ~bank.request;
        end
    end

endmodule

`default_nettype wire

// ### tb/pie_enable_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module pie_enable_monitor
    import pie_pkg::*;
(
    // APB side.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sampled sources and their requests.
    input wire logic parallel_slave_flag,
    input wire logic parallel_slave_irq_req,
    input wire logic comparator_flag,
    input wire logic comparator_irq_req,
    input wire logic low_voltage_flag,
    input wire logic low_voltage_irq_req,
    input wire logic invalid_msg_flag,
    input wire logic invalid_msg_irq_req
);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && pready;
    endsequence

    access_answered_a: assert property (setup_s |=> penable ##[0:3] answer_s)
        else $error("access not answered in time");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    error_with_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("error reported outside an answer");
    unmapped_error_a: assert property (pready && paddr > PIE_OFF_REQ_VIEW |-> pslverr)
        else $error("unmapped access not refused");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside an answer");
    unused_bits_zero_a: assert property (
        pready && !pwrite && paddr == PIE_OFF_ENABLE_B |-> (prdata & 32'hffffffb0) == 32'h0)
        else $error("unimplemented enable bits read nonzero");
    slave_gate_a: assert property (parallel_slave_irq_req |-> $past(parallel_slave_flag))
        else $error("parallel slave request without flag");
    comparator_gate_a: assert property ($fell(comparator_flag) |=> !comparator_irq_req)
        else $error("comparator request outlived its flag");
    voltage_gate_a: assert property (!$past(low_voltage_flag) |-> !low_voltage_irq_req)
        else $error("low voltage request without flag");
    invalid_gate_a: assert property ($rose(invalid_msg_irq_req) |-> $past(invalid_msg_flag))
        else $error("invalid message request without flag");
endmodule

`default_nettype wire

// ### tb/pie_source_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for the peripheral flag sources and the core's request inputs.
module pie_source_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Commanded flag levels and the flags driven to the block.
    input wire logic [23:0] ev,
    output logic [23:0] flags,
    // Requests as the core latches them.
    input wire logic [23:0] reqs,
    output logic [23:0] core_req
);
    // Sources are quiet in reset, so the first release shows clean rising edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 24'h000000;
            core_req <= 24'h000000;
        end else begin
            flags <= ev;
            core_req <= reqs;
        end
    end
endmodule

`default_nettype wire

// ### tb/peripheral_interrupt_enables_bench.sv
`timescale 1ns/1ps
`default_nettype none

module peripheral_interrupt_enables_bench
    import pie_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] rb;
        logic [23:0] fl;
        logic [23:0] rq;
    } pie_row_t;
    pie_row_t rows [6] = '{
        '{8'hff, 8'hff, 8'h00, 8'h4f, 24'hffffff, 24'h004fff},
        '{8'haa, 8'h55, 8'h5a, 8'h45, 24'hffffff, 24'h5a45aa},
        '{8'h55, 8'haa, 8'ha5, 8'h0a, 24'hffffff, 24'ha50a55},
        '{8'hff, 8'hff, 8'hff, 8'h4f, 24'h0f0f0f, 24'h0f0f0f},
        '{8'hff, 8'hff, 8'hff, 8'h4f, 24'hf0f0f0, 24'hf040f0},
        '{8'h00, 8'h00, 8'h00, 8'h00, 24'hffffff, 24'h000000}};
    logic [31:0] rst_exp [5] = '{32'h0, 32'h0, 32'h000000ff, 32'h00ff0000, 32'h0};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [23:0] ev = 24'h000000;
    logic [23:0] f;
    logic [23:0] core_req;
    wire logic [23:0] q;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int tests_run = 0;

    // Bank B has no sources at bits 7, 5 and 4.
    assign q[15] = 1'b0;
    assign q[13:12] = 2'b00;

    always #12.5 pclk = ~pclk;

    pie_enable_top pie_enable_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .parallel_slave_flag(f[7]), .converter_flag(f[6]), .serial_rx_flag(f[5]),
        .serial_tx_flag(f[4]), .sync_serial_flag(f[3]), .capcomp_a_flag(f[2]),
        .period_timer_match_flag(f[1]), .timer_a_overflow_flag(f[0]),
        .comparator_flag(f[14]), .bus_collision_flag(f[11]), .low_voltage_flag(f[10]),
        .timer_c_overflow_flag(f[9]), .capcomp_b_flag(f[8]), .invalid_msg_flag(f[23]),
        .bus_wake_flag(f[22]), .bus_error_flag(f[21]), .tx_buffer2_flag(f[20]),
        .tx_buffer1_flag(f[19]), .tx_buffer0_flag(f[18]), .rx_buffer1_flag(f[17]),
        .rx_buffer0_flag(f[16]), .parallel_slave_irq_req(q[7]), .converter_irq_req(q[6]),
        .serial_rx_irq_req(q[5]), .serial_tx_irq_req(q[4]), .sync_serial_irq_req(q[3]),
        .capcomp_a_irq_req(q[2]), .period_timer_match_irq_req(q[1]),
        .timer_a_overflow_irq_req(q[0]), .comparator_irq_req(q[14]),
        .bus_collision_irq_req(q[11]), .low_voltage_irq_req(q[10]),
        .timer_c_overflow_irq_req(q[9]), .capcomp_b_irq_req(q[8]),
        .invalid_msg_irq_req(q[23]), .bus_wake_irq_req(q[22]), .bus_error_irq_req(q[21]),
        .tx_buffer2_irq_req(q[20]), .tx_buffer1_irq_req(q[19]), .tx_buffer0_irq_req(q[18]),
        .rx_buffer1_irq_req(q[17]), .rx_buffer0_irq_req(q[16]), .irq(irq));

    pie_source_model pie_source_model_inst (
        .pclk(pclk), .presetn(presetn), .ev(ev), .flags(f), .reqs(q), .core_req(core_req));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is sampled high; the watchdog bounds the wait.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        ev <= 24'hffffff;
        repeat (4) @(posedge pclk);
        check({8'h00, core_req}, 32'h00ff0000);
        check({31'h0, irq}, 32'h0);
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            check(rd, rst_exp[k]);
        end
        foreach (rows[i]) begin
            apb(1'b1, PIE_OFF_ENABLE_A, {24'h0, rows[i].a});
            apb(1'b1, PIE_OFF_ENABLE_B, {24'h0, rows[i].b});
            apb(1'b1, PIE_OFF_CAN_ENABLE, {24'h0, rows[i].c});
            ev <= rows[i].fl;
            repeat (4) @(posedge pclk);
            check({24'h0, core_req[7:0]}, {24'h0, rows[i].rq[7:0]});
            check({24'h0, core_req[15:8]}, {24'h0, rows[i].rq[15:8]});
            check({24'h0, core_req[23:16]}, {24'h0, rows[i].rq[23:16]});
            apb(1'b0, PIE_OFF_ENABLE_B, 32'h0);
            check(rd, {24'h0, rows[i].rb});
        end
        // Raise, mask and clear the summary interrupt.
        apb(1'b1, PIE_OFF_ENABLE_A, 32'h000000ff);
        ev <= 24'h000000;
        repeat (4) @(posedge pclk);
        apb(1'b1, PIE_OFF_IRQ_STATUS, 32'h00ffffff);
        apb(1'b1, PIE_OFF_IRQ_MASK, 32'h00000002);
        ev <= 24'h000001;
        repeat (4) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        ev <= 24'h000003;
        repeat (4) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, PIE_OFF_IRQ_STATUS, 32'h0);
        check(rd, 32'h00000003);
        apb(1'b1, PIE_OFF_IRQ_STATUS, 32'h00000002);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        // A disabled source loses its request but keeps its flag level.
        apb(1'b1, PIE_OFF_ENABLE_A, 32'h00000000);
        repeat (4) @(posedge pclk);
        check({8'h00, core_req}, 32'h0);
        apb(1'b1, PIE_OFF_ENABLE_A, 32'h000000ff);
        repeat (4) @(posedge pclk);
        check({8'h00, core_req}, 32'h00000003);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, PIE_OFF_REQ_VIEW, 32'h0);
        check({31'h0, err}, 32'h0);
        apb(1'b0, PIE_OFF_REQ_VIEW, 32'h0);
        check(rd, 32'h00000003);
        apb(1'b0, 8'h18, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, 8'h18, 32'h000000ff);
        check({31'h0, err}, 32'h1);
        // A reset in mid-run must bring every bank back to its power-on value.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            check(rd, rst_exp[k]);
        end
        apb(1'b0, PIE_OFF_IRQ_STATUS, 32'h0);
        check(rd, 32'h0);
        check({8'h00, core_req}, 32'h0);
        check({31'h0, irq}, 32'h0);
        stop_test();
    end
endmodule

bind pie_enable_top pie_enable_monitor pie_enable_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .parallel_slave_flag(parallel_slave_flag), .parallel_slave_irq_req(parallel_slave_irq_req),
    .comparator_flag(comparator_flag), .comparator_irq_req(comparator_irq_req),
    .low_voltage_flag(low_voltage_flag), .low_voltage_irq_req(low_voltage_irq_req),
    .invalid_msg_flag(invalid_msg_flag), .invalid_msg_irq_req(invalid_msg_irq_req));

`default_nettype wire
